// ### core/hvbc_pkg.sv
// Package of constants and carrier types for the hardware volume button block
//
// Behaviour
// - Shared pin: control out, chip select, or down
// - Enable setting turns shared pin into down input
// - Down press lowers left and right volume
// - Mute honoured only while enable setting set
// - Format bit picks momentary mute or none
// - Up press raises left and right volume
// - Volume function outranks other shared-pin uses
// - Format bit comes from global configuration byte
package hvbc_pkg;
   localparam int VOL_W = 6;
   localparam logic [5:0] VOL_MAX = 6'h3F;
   localparam logic [5:0] VOL_RST = 6'h00;
   // Position of the format bit inside the global configuration byte
   localparam int GCB_FMT_BIT = 1;
   // Auto-repeat for a held button
   localparam int REPEAT_NS = 200000000;
   localparam int CLK_NS = 25;
   localparam int REPEAT_CYC = REPEAT_NS / CLK_NS;
   localparam int REP_W = 24;

   typedef struct packed {
      logic down;
      logic up;
      logic mute;
   } hvbc_btn_t;

   typedef struct packed {
      logic [VOL_W-1:0] left;
      logic [VOL_W-1:0] right;
   } hvbc_vol_t;
endpackage

// ### core/hvbc_top.sv
// Volume button control: pin mux, synchronisers, stepping and mute
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Three-stage synchroniser with agreement filter, one per button pin
module hvbc_sync import hvbc_pkg::*; #(
   parameter logic IDLE = 1'b1
) (
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic pin_n, // Raw pin level
   output logic level_q, // Accepted level
   output logic level_d // Level accepted at the next edge
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic acc_q;
   logic acc_d;
   logic agree;

   ////////////////////////////////////////////////////////////////////////
   // First stage may go metastable; only the second stage reads it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s1_q <= IDLE;
      end else begin
         s1_q <= pin_n;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s2_q <= IDLE;
      end else begin
         s2_q <= s1_q;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s3_q <= IDLE;
      end else begin
         s3_q <= s2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // A change counts once the second and third stages agree
   assign agree = (s2_q == s3_q);
   assign acc_d = agree ? s3_q : acc_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc_q <= IDLE;
      end else begin
         acc_q <= acc_d;
      end
   end

   assign level_q = acc_q;
   assign level_d = acc_d;
endmodule // hvbc_sync

////////////////////////////////////////////////////////////////////////
// Saturating one-step volume update for a single channel
module hvbc_vol_step import hvbc_pkg::*; (
   input wire logic [VOL_W-1:0] cur, // Present level
   input wire logic step_dn, // Lower by one step
   input wire logic step_up, // Raise by one step
   output logic [VOL_W-1:0] nxt // Next level
);
   logic at_min;
   logic at_max;
   logic [VOL_W-1:0] dec_val;
   logic [VOL_W-1:0] inc_val;

   // Ends of the range hold rather than wrap
   assign at_min = (cur == '0);
   assign at_max = (cur == VOL_MAX);
   assign dec_val = at_min ? cur : cur - 1'b1;
   assign inc_val = at_max ? cur : cur + 1'b1;
   // Down wins if the caller raises both at once
   assign nxt = step_dn ? dec_val : (step_up ? inc_val : cur);
endmodule // hvbc_vol_step

////////////////////////////////////////////////////////////////////////
module hvbc_top import hvbc_pkg::*; #(
   parameter int REPEAT_CYCLES = REPEAT_CYC
) (
   input wire logic clk_sys, // 40 MHz clock
   input wire logic resetn, // Async reset, active low
   input wire logic volume_pins_enable, // Volume pins enable setting
   input wire logic [7:0] global_cfg_byte, // Global configuration byte
   input wire logic alt_cs_strap, // Alternate chip select strap
   input wire logic aux_ctl_value, // Auxiliary control output value
   input wire logic alt_cs_match_n, // Alternate decode hit, active low
   input wire logic shared_pin_in, // Shared pin input level
   input wire logic up_pin_in_n, // Volume-up button, active low
   input wire logic mute_pin_in_n, // Mute button, active low
   output logic shared_pin_out, // Shared pin output level
   output logic shared_pin_oe, // Shared pin output enable
   output logic [VOL_W-1:0] vol_left, // Left master volume
   output logic [VOL_W-1:0] vol_right, // Right master volume
   output logic mute_out // Master mute
);
   ////////////////////////////////////////////////////////////////////////
   hvbc_btn_t stable_q, stable_d;
   hvbc_btn_t raw_n;
   hvbc_vol_t vol_q, vol_d;
   logic [REP_W-1:0] rep_q, rep_d;
   logic pin_out_q, pin_oe_q, mute_q;
   logic pin_out_d, pin_oe_d, mute_d;
   logic fmt_momentary;
   logic down_act, up_act, mute_act;
   logic down_fall, up_fall, held, rep_hit, step_dn, step_up;
   logic down_lvl_q, up_lvl_q, mute_lvl_q;
   logic down_lvl_d, up_lvl_d, mute_lvl_d;
   logic [VOL_W-1:0] left_d, right_d;

   ////////////////////////////////////////////////////////////////////////
   // Input is the shared pin only when volume function owns it
   assign raw_n.down = volume_pins_enable ? shared_pin_in : 1'b1;
   assign raw_n.up = up_pin_in_n;
   assign raw_n.mute = mute_pin_in_n;

   // Idle level high, so no false press follows reset
   hvbc_sync #(.IDLE(1'b1)) i_sync_down (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_n(raw_n.down),
      .level_q(down_lvl_q),
      .level_d(down_lvl_d)
   );

   hvbc_sync #(.IDLE(1'b1)) i_sync_up (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_n(raw_n.up),
      .level_q(up_lvl_q),
      .level_d(up_lvl_d)
   );

   hvbc_sync #(.IDLE(1'b1)) i_sync_mute (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pin_n(raw_n.mute),
      .level_q(mute_lvl_q),
      .level_d(mute_lvl_d)
   );

   assign stable_q = {down_lvl_q, up_lvl_q, mute_lvl_q};
   assign stable_d = {down_lvl_d, up_lvl_d, mute_lvl_d};

   ////////////////////////////////////////////////////////////////////////
   assign fmt_momentary = global_cfg_byte[GCB_FMT_BIT];
   assign down_act = volume_pins_enable & ~stable_q.down;
   assign up_act = volume_pins_enable & ~stable_q.up;
   assign mute_act = volume_pins_enable & fmt_momentary & ~stable_q.mute;
   assign down_fall = volume_pins_enable & stable_q.down & ~stable_d.down;
   assign up_fall = volume_pins_enable & stable_q.up & ~stable_d.up;
   assign held = down_act ^ up_act;
   assign rep_hit = held & (rep_q == REP_W'(REPEAT_CYCLES - 1));
   assign rep_d = (held & ~rep_hit) ? rep_q + 1'b1 : '0;
   // A press counts only if the other button is up at the next edge
   assign step_dn = (down_fall & stable_d.up) | (rep_hit & down_act);
   assign step_up = (up_fall & stable_d.down) | (rep_hit & up_act);

   // Both channels step together from one decision
   hvbc_vol_step i_step_left (
      .cur(vol_q.left),
      .step_dn(step_dn),
      .step_up(step_up),
      .nxt(left_d)
   );

   hvbc_vol_step i_step_right (
      .cur(vol_q.right),
      .step_dn(step_dn),
      .step_up(step_up),
      .nxt(right_d)
   );

   assign vol_d = {left_d, right_d};
   assign mute_d = mute_act;

   ////////////////////////////////////////////////////////////////////////
   // Volume enable first, then strap, else auxiliary output
   assign pin_oe_d = ~volume_pins_enable;
   assign pin_out_d = volume_pins_enable ? 1'b0 :
                      alt_cs_strap ? alt_cs_match_n : aux_ctl_value;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         vol_q <= {VOL_RST, VOL_RST};
      end else begin
         vol_q <= vol_d;
      end
   end

   // Repeat counter restarts whenever no single button is held
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rep_q <= '0;
      end else begin
         rep_q <= rep_d;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mute_q <= 1'b0;
      end else begin
         mute_q <= mute_d;
      end
   end

   // Pin released during reset until the mux settles
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_out_q <= 1'b0;
      end else begin
         pin_out_q <= pin_out_d;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_oe_q <= 1'b0;
      end else begin
         pin_oe_q <= pin_oe_d;
      end
   end

   assign shared_pin_out = pin_out_q;
   assign shared_pin_oe = pin_oe_q;
   assign vol_left = vol_q.left;
   assign vol_right = vol_q.right;
   assign mute_out = mute_q;
endmodule // hvbc_top

// ### bench/hvbc_chk.sv
// Checker for the volume button block
`timescale 1ns/1ps
module hvbc_chk import hvbc_pkg::*; (
   input logic clk_sys, resetn, volume_pins_enable, // Clock, reset, enable
   input logic shared_pin_in, up_pin_in_n, // Button pins
   input logic [7:0] global_cfg_byte, // Config
   input logic shared_pin_out, shared_pin_oe, mute_out, // Outputs
   input logic [VOL_W-1:0] vol_left, vol_right // Volumes
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   pin_free_a: assert property (volume_pins_enable |=> !shared_pin_oe) else $error("pin driven");
   pin_low_a: assert property (volume_pins_enable |=> !shared_pin_out) else $error("pin out high");
   chan_pair_a: assert property (vol_left == vol_right) else $error("channels differ");
   one_step_a: assert property ($changed(vol_left) |-> vol_left == $past(vol_left) + 6'h01
      || vol_left == $past(vol_left) - 6'h01) else $error("step not one");
   down_cause_a: assert property ($changed(vol_left) && vol_left < $past(vol_left)
      |-> !$past(shared_pin_in, 3)) else $error("down without press");
   up_cause_a: assert property ($changed(vol_left) && vol_left > $past(vol_left)
      |-> !$past(up_pin_in_n, 3)) else $error("up without press");
   mute_gate_a: assert property (!volume_pins_enable [*6] |-> !mute_out) else $error("mute off");
   mute_fmt_a: assert property (!global_cfg_byte[GCB_FMT_BIT] [*6] |-> !mute_out) else $error("mute fmt");
endmodule // hvbc_chk
bind hvbc_top hvbc_chk i_chk (.*);

// ### bench/hvbc_btn_mdl.sv
// Push buttons with pull-ups
`timescale 1ns/1ps
module hvbc_btn_mdl import hvbc_pkg::*; (
   input hvbc_btn_t press, // Buttons held
   input logic pin_out, pin_oe, // Shared pin drive
   output logic shared_pin_in, up_n, mute_n // Pin levels
);
   assign shared_pin_in = pin_oe ? pin_out : !press.down;
   assign up_n = !press.up;
   assign mute_n = !press.mute;
endmodule // hvbc_btn_mdl

// ### bench/hvbc_top_tb.sv
// Self-checking bench for the volume button block
`timescale 1ns/1ps
module hvbc_top_tb import hvbc_pkg::*;;
   logic clk_sys = 0, resetn = 0, en = 1, strap = 0, aux = 0, match_n = 1;
   logic [7:0] cfg = 8'h02;
   hvbc_btn_t btn = '0;
   logic pin, up_n, mute_n, p_out, p_oe, mute;
   logic [VOL_W-1:0] vl, vr;
   int ev = 0, fail_count = 0, total_checks = 0;
   hvbc_top #(.REPEAT_CYCLES(20)) i_dut (.clk_sys, .resetn, .volume_pins_enable(en), .global_cfg_byte(cfg),
      .alt_cs_strap(strap), .aux_ctl_value(aux), .alt_cs_match_n(match_n), .shared_pin_in(pin), .up_pin_in_n(up_n),
      .mute_pin_in_n(mute_n), .shared_pin_out(p_out), .shared_pin_oe(p_oe), .vol_left(vl), .vol_right(vr),
      .mute_out(mute));
   hvbc_btn_mdl i_btn (.press(btn), .pin_out(p_out), .pin_oe(p_oe), .shared_pin_in(pin), .up_n, .mute_n);
   initial forever #12.5 clk_sys = !clk_sys;
   task automatic check(string n, logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_n(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic push(hvbc_btn_t b, int n);
      btn = b;
      wait_n(n);
      btn = '0;
      wait_n(12);
      check("vol_left", {2'h0, vl}, ev[7:0]);
      check("vol_right", {2'h0, vr}, ev[7:0]);
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      void'($urandom(20857));
      wait_n(3);
      resetn = 1;
      // Saturating up presses, held down repeat, both together
      repeat (66) begin
         ev = ev < 63 ? ev + 1 : 63;
         push(3'b010, 8);
      end
      ev -= 3;
      push(3'b100, 50);
      push(3'b110, 8);
      for (int i = 0; i < 3; i++) begin
         en = i != 2;
         cfg = {6'h0, i != 0, 1'b0};
         btn = 3'b001;
         wait_n(8);
         check("mute", {7'h0, mute}, {7'h0, i == 1});
         btn = '0;
         wait_n(8);
         check("mute", {7'h0, mute}, 8'h00);
      end
      repeat (4) begin
         {strap, aux, match_n} = 3'($urandom);
         push(3'b110, 8);
         check("pin_out", {7'h0, p_out}, {7'h0, strap ? match_n : aux});
         check("pin_oe", {7'h0, p_oe}, 8'h01);
      end
      final_report();
   end
   initial begin
      wait_n(5000);
      fail_count++;
      final_report();
   end
endmodule // hvbc_top_tb
